// ### fsf_fault_flags.sv
// Purpose: mid bits of the fault status word with apb access and interrupt
// Assumes: core fault and stacking logic drives its strobes on this clock
// Notes: all outputs come from flip-flops; status events also feed the irq
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fsf_defs.svh"

// Functional notes
// - issued prefetch error sets instruction error flag
// - instruction error blocks bus fault address capture
// - address valid flag follows memory address capture
// - bits six and five read zero
// - push violation on entry sets its flag
// - stack pointer still updates after push violation
// - push violation blocks memory address capture
// - writing one clears flag, zero keeps
module fsf_fault_flags
   import fsf_pkg::*;
(
   input  wire logic                  clock,                     // core clock, 25 mhz
   input  wire logic                  rst_n,                     // async reset, active low
   input  wire logic                  psel,                      // apb select
   input  wire logic                  penable,                   // apb access phase
   input  wire logic                  pwrite,                    // apb direction, high write
   input  wire logic [`FSF_ADDR_W-1:0] paddr,                    // apb byte address
   input  wire logic [31:0]           pwdata,                    // apb write data
   output logic      [31:0]           prdata,                    // apb read data
   output logic                       pready,                    // apb ready
   output logic                       pslverr,                   // apb error, unmapped
   input  wire logic                  core_issue_valid,          // core issues an instruction
   input  wire logic                  core_issue_prefetch_err,   // that instruction had a fetch error
   input  wire logic                  core_bus_addr_capture_req, // core wants bus fault address kept
   input  wire logic                  core_mem_addr_capture_req, // core wants mem fault address kept
   input  wire logic                  core_entry_push_active,    // context push for entry in flight
   input  wire logic                  core_entry_push_violation, // push access violated protection
   input  wire logic                  core_entry_push_done,      // context push finished
   output logic                       instr_fetch_error_flag,    // bit 8 flag
   output logic                       mem_fault_addr_valid,      // bit 7 flag
   output logic                       entry_push_violation_flag, // bit 4 flag
   output logic                       bus_fault_addr_capture_en, // load bus_fault_address_reg
   output logic                       mem_fault_addr_capture_en, // load mem_fault_address_reg
   output logic                       stack_pointer_update_en,   // commit new stack_pointer
   output logic                       fault_irq                  // level interrupt
);

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------

   // sticky update with set winning over clear
   function automatic fsf_word_t w1c_next(input fsf_word_t cur, input fsf_word_t set, input fsf_word_t clr);
      w1c_next = set | (cur & ~clr);
   endfunction

   // place the three live bits into the status layout
   function automatic fsf_word_t pack_bits(input logic instr_b, input logic mem_b, input logic push_b);
      fsf_word_t w;
      w = `FSF_FLAGS_RST;
      w[`FSF_BIT_INSTR_ERR] = instr_b;
      w[`FSF_BIT_MEM_VALID] = mem_b;
      w[`FSF_BIT_PUSH_VIOL] = push_b;
      pack_bits = w;
   endfunction

   // address decode, if chain
   function automatic fsf_sel_t decode_sel(input logic [`FSF_ADDR_W-1:0] a);
      if (a == `FSF_FLAGS_OFS) begin
         decode_sel = FSF_SEL_FLAGS;
      end else if (a == `FSF_IRQ_STAT_OFS) begin
         decode_sel = FSF_SEL_IRQ_STAT;
      end else if (a == `FSF_IRQ_MASK_OFS) begin
         decode_sel = FSF_SEL_IRQ_MASK;
      end else begin
         decode_sel = FSF_SEL_NONE;
      end
   endfunction

   // ---------------------------------------------------------------
   // fault events from the core
   // ---------------------------------------------------------------
   logic instr_err_evt;     // issued instruction carried fetch error
   logic push_viol_evt;     // protection violation while pushing context
   logic mem_capture_go;    // memory fault address really captured
   logic bus_capture_go;    // bus fault address really captured

   // a fetch error alone does nothing; only the issue attempt counts
   assign instr_err_evt  = core_issue_valid & core_issue_prefetch_err;
   assign push_viol_evt  = core_entry_push_active & core_entry_push_violation;
   // the address of a failed push is meaningless, so it is never kept
   assign mem_capture_go = core_mem_addr_capture_req & ~push_viol_evt;
   // an instruction bus error has no data address worth keeping
   assign bus_capture_go = core_bus_addr_capture_req & ~instr_err_evt;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   fsf_bus_state_t bus_state_reg;   // answer sequencer state
   fsf_bus_state_t bus_state_next;  // its next value
   fsf_sel_t       sel_now;         // decoded register
   logic           access_phase;    // psel and penable both high
   logic           xfer_done;       // completing edge of a transfer
   logic           wr_done;         // write takes effect
   logic           rd_done;         // read data taken
   logic           wr_flags;        // write to flags register
   logic           wr_mask;         // write to irq mask
   logic           rd_stat;         // read of irq status, clears it
   fsf_word_t      clr_bits;        // write-one clear pattern

   assign sel_now      = decode_sel(paddr);
   assign access_phase = psel & penable;
   assign xfer_done    = access_phase & pready;
   assign wr_done      = xfer_done & pwrite;
   assign rd_done      = xfer_done & ~pwrite;
   assign wr_flags     = wr_done & (sel_now == FSF_SEL_FLAGS);
   assign wr_mask      = wr_done & (sel_now == FSF_SEL_IRQ_MASK);
   assign rd_stat      = rd_done & (sel_now == FSF_SEL_IRQ_STAT);
   // reserved bits 6:5 can never be cleared or set, writes there are dropped
   assign clr_bits     = wr_flags ? (pwdata & `FSF_LIVE_MASK) : `FSF_FLAGS_RST;

   // ---------------------------------------------------------------
   // the three status flags
   // ---------------------------------------------------------------

   // bit 8 instruction error flag
   fsf_sticky_flag u_instr_flag (
      .clock     (clock),
      .rst_n     (rst_n),
      .set_evt   (instr_err_evt),
      .clear_req (clr_bits[`FSF_BIT_INSTR_ERR]),
      .flag      (instr_fetch_error_flag)
   );

   // bit 7 memory fault address valid; the hard fault handler clears it
   fsf_sticky_flag u_mem_valid_flag (
      .clock     (clock),
      .rst_n     (rst_n),
      .set_evt   (mem_capture_go),
      .clear_req (clr_bits[`FSF_BIT_MEM_VALID]),
      .flag      (mem_fault_addr_valid)
   );

   // bit 4 entry push violation flag
   fsf_sticky_flag u_push_flag (
      .clock     (clock),
      .rst_n     (rst_n),
      .set_evt   (push_viol_evt),
      .clear_req (clr_bits[`FSF_BIT_PUSH_VIOL]),
      .flag      (entry_push_violation_flag)
   );

   // ---------------------------------------------------------------
   // capture enables and stack pointer commit
   // ---------------------------------------------------------------

   // registered strobes; address loads land with the flag update
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_fault_addr_capture_en <= 1'b0;
         mem_fault_addr_capture_en <= 1'b0;
         stack_pointer_update_en   <= 1'b0;
      end else begin
         bus_fault_addr_capture_en <= bus_capture_go;
         mem_fault_addr_capture_en <= mem_capture_go;
         // violation does not hold the pointer back; pushed data may be wrong
         stack_pointer_update_en   <= core_entry_push_done;
      end
   end

   // ---------------------------------------------------------------
   // interrupt status and mask
   // ---------------------------------------------------------------
   fsf_word_t irq_stat_reg;    // sticky event bits, read clears
   fsf_word_t irq_stat_next;   // next status
   fsf_word_t irq_mask_reg;    // enable per event
   fsf_word_t irq_mask_next;   // next mask
   fsf_word_t irq_evt;         // events this cycle
   fsf_word_t irq_rd_clr;      // clear pattern from a status read

   assign irq_evt       = pack_bits(instr_err_evt, mem_capture_go, push_viol_evt);
   // clear only what the read returned: prdata is captured one edge before the
   // completing edge, so an event landing in between stays pending, not lost
   assign irq_rd_clr    = rd_stat ? (prdata & `FSF_LIVE_MASK) : `FSF_IRQ_STAT_RST;
   // an event in the reading cycle survives the read
   assign irq_stat_next = w1c_next(irq_stat_reg, irq_evt, irq_rd_clr);
   assign irq_mask_next = wr_mask ? (pwdata & `FSF_LIVE_MASK) : irq_mask_reg;

   // status, mask and the level output
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_reg <= `FSF_IRQ_STAT_RST;
         irq_mask_reg <= `FSF_IRQ_MASK_RST;
         fault_irq    <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         fault_irq    <= |(irq_stat_next & irq_mask_next);
      end
   end

   // ---------------------------------------------------------------
   // apb answer sequencer
   // ---------------------------------------------------------------
   fsf_word_t rd_word;        // data for the addressed register
   logic      answer_now;     // raise pready at next edge
   logic      unmapped_now;   // address hits nothing

   assign unmapped_now = (sel_now == FSF_SEL_NONE);
   // every register reads zero in bits 6:5 and above bit 8
   assign rd_word = (sel_now == FSF_SEL_FLAGS) ?
                       pack_bits(instr_fetch_error_flag, mem_fault_addr_valid, entry_push_violation_flag) :
                    (sel_now == FSF_SEL_IRQ_STAT) ? irq_stat_reg :
                    (sel_now == FSF_SEL_IRQ_MASK) ? irq_mask_reg : `FSF_FLAGS_RST;
   assign answer_now = (bus_state_reg == FSF_BUS_WAIT);

   // two wait states, then a one-cycle ready
   always_comb begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         FSF_BUS_IDLE: begin
            if (access_phase) begin
               bus_state_next = FSF_BUS_WAIT;
            end
         end
         FSF_BUS_WAIT: begin
            bus_state_next = FSF_BUS_ANSWER;
         end
         FSF_BUS_ANSWER: begin
            bus_state_next = FSF_BUS_IDLE;
         end
         default: begin
            bus_state_next = FSF_BUS_IDLE;
         end
      endcase
   end

   // state and registered bus outputs
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_state_reg <= FSF_BUS_IDLE;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
         prdata        <= `FSF_FLAGS_RST;
      end else begin
         bus_state_reg <= bus_state_next;
         pready        <= answer_now;
         pslverr       <= answer_now & unmapped_now;
         // read data is sampled on the edge that raises pready, one edge before the completing edge
         prdata        <= (answer_now & ~pwrite) ? rd_word : `FSF_FLAGS_RST;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // a write of one to a flag bit completes this cycle
   sequence instr_clear_s;
      wr_flags && pwdata[`FSF_BIT_INSTR_ERR];
   endsequence
   sequence push_clear_s;
      wr_flags && pwdata[`FSF_BIT_PUSH_VIOL];
   endsequence

   instr_set_cause_a: assert property ($rose(instr_fetch_error_flag) |->
         $past(core_issue_valid) && $past(core_issue_prefetch_err))
      else $error("instruction error flag set without issued faulty instruction");
   fetch_alone_a: assert property (
         (!instr_fetch_error_flag && !(core_issue_valid && core_issue_prefetch_err))
         |=> !instr_fetch_error_flag)
      else $error("instruction error flag set by fetch error alone");
   bus_capture_block_a: assert property (instr_err_evt |=> !bus_fault_addr_capture_en)
      else $error("bus fault address captured on instruction error");
   valid_follows_capture_a: assert property (mem_fault_addr_capture_en |-> mem_fault_addr_valid)
      else $error("memory address captured but valid flag clear");
   rsvd_read_zero_a: assert property (pready |-> prdata[`FSF_BIT_RSVD_HI:`FSF_BIT_RSVD_LO] == 2'b00)
      else $error("reserved bits read nonzero");
   push_flag_set_a: assert property (push_viol_evt |=> entry_push_violation_flag)
      else $error("push violation did not set its flag");
   sp_still_moves_a: assert property ((core_entry_push_done && entry_push_violation_flag) |=>
         stack_pointer_update_en)
      else $error("stack pointer held back by push violation");
   mem_capture_block_a: assert property (push_viol_evt |=> !mem_fault_addr_capture_en)
      else $error("memory fault address captured on push violation");
   flag_clear_one_a: assert property ((push_clear_s and !push_viol_evt) |=>
         !entry_push_violation_flag)
      else $error("write of one did not clear push violation flag");
   flag_keep_zero_a: assert property ((wr_flags && !pwdata[`FSF_BIT_PUSH_VIOL] && entry_push_violation_flag)
         |=> entry_push_violation_flag)
      else $error("write of zero cleared push violation flag");
   set_wins_clear_a: assert property ((instr_clear_s and instr_err_evt) |=>
         instr_fetch_error_flag)
      else $error("clear beat a simultaneous set");
   irq_level_a: assert property (fault_irq == |(irq_stat_reg & irq_mask_reg))
      else $error("interrupt level disagrees with status and mask");
   ready_latency_a: assert property ((access_phase && bus_state_reg == FSF_BUS_IDLE) |=>
         !pready ##1 pready)
      else $error("apb answer latency wrong");

endmodule // fsf_fault_flags

// ### fsf_defs.svh
// Purpose: offsets, field positions, reset values and bus timing for the fault flag slice
// Assumes: included by its bare name from the fault flags module and the bench
// Notes: all numbers of the block live here as macros
`ifndef FSF_DEFS_SVH
`define FSF_DEFS_SVH

// apb address width and register byte offsets
`define FSF_ADDR_W           12
`define FSF_FLAGS_OFS        12'h000
`define FSF_IRQ_STAT_OFS     12'h004
`define FSF_IRQ_MASK_OFS     12'h008

// field positions in the fault status layout
`define FSF_BIT_INSTR_ERR    8
`define FSF_BIT_MEM_VALID    7
`define FSF_BIT_RSVD_HI      6
`define FSF_BIT_RSVD_LO      5
`define FSF_BIT_PUSH_VIOL    4

// writable and readable bits of every register in this slice
`define FSF_LIVE_MASK        32'h0000_0190

// reset values
`define FSF_FLAGS_RST        32'h0000_0000
`define FSF_IRQ_STAT_RST     32'h0000_0000
`define FSF_IRQ_MASK_RST     32'h0000_0000

// apb answer latency: unused, the answer sequencer inserts two wait states in the access phase
`define FSF_WAIT_STATES      1

`endif

// ### fsf_pkg.sv
// Purpose: shared types of the fault flag slice
// Assumes: fsf_defs.svh holds every number
// Notes: types only, no constants
package fsf_pkg;
   // one apb data word
   typedef logic [31:0] fsf_word_t;

   // register selected by the current apb address
   typedef enum logic [1:0] {
      FSF_SEL_FLAGS,
      FSF_SEL_IRQ_STAT,
      FSF_SEL_IRQ_MASK,
      FSF_SEL_NONE
   } fsf_sel_t;

   // apb slave answer sequencer
   typedef enum logic [1:0] {
      FSF_BUS_IDLE,
      FSF_BUS_WAIT,
      FSF_BUS_ANSWER
   } fsf_bus_state_t;
endpackage

// ### fsf_sticky_flag.sv
// Purpose: one write-one-to-clear status flag
// Assumes: set and clear arrive from logic on the same clock
// Notes: a set in the clearing cycle wins, so no event is lost
`timescale 1ns/1ps
module fsf_sticky_flag (
   input  wire logic clock,      // core clock
   input  wire logic rst_n,      // async reset, active low
   input  wire logic set_evt,    // hardware event, one cycle
   input  wire logic clear_req,  // software write of one
   output logic      flag        // sticky flag
);
   logic flag_next;              // next flag value

   // set has priority over clear
   assign flag_next = set_evt | (flag & ~clear_req);

   // flag storage
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else begin
         flag <= flag_next;
      end
   end
endmodule // fsf_sticky_flag

// ### fsf_core_model.sv
// Purpose: stand-in for the core fault detection and entry push logic
// Assumes: bench pulses each request input for one cycle
// Notes: all outputs are flops, so strobes sit cleanly in one core cycle
`timescale 1ns/1ps
module fsf_core_model (
   input  wire logic       clock,          // core clock
   input  wire logic       rst_n,          // async reset, active low
   input  wire logic       issue_req,      // issue one instruction
   input  wire logic       fetch_err_req,  // its prefetch failed
   input  wire logic       bus_cap_req,    // ask for bus address capture
   input  wire logic       mem_cap_req,    // ask for mem address capture
   input  wire logic       push_start,     // begin an entry push
   input  wire logic       push_viol,      // violate on first push cycle
   input  wire logic [1:0] push_len,       // push cycles minus one
   output logic            issue_valid,    // instruction issue strobe
   output logic            prefetch_err,   // prefetch error qualifier
   output logic            bus_cap,        // bus address capture request
   output logic            mem_cap,        // mem address capture request
   output logic            push_active,    // push in flight, level
   output logic            push_violation, // push access violated
   output logic            push_done       // push finished
);
   logic [1:0] left_reg; // push cycles still to run

   // strobes follow the bench one cycle later
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {issue_valid, prefetch_err, bus_cap, mem_cap} <= 4'h0;
         {push_active, push_violation, push_done} <= 3'h0;
         left_reg <= 2'h0;
      end else begin
         issue_valid    <= issue_req;
         prefetch_err   <= fetch_err_req;              // may come without issue: a fetch never issued
         bus_cap        <= bus_cap_req;
         mem_cap        <= mem_cap_req;
         push_violation <= push_start & push_viol;    // only in an active push cycle
         push_done      <= push_active & (left_reg == 2'h0);
         if (push_start) begin                        // new push
            push_active <= 1'b1;
            left_reg    <= push_len;
         end else if (push_active) begin              // count the push down
            push_active <= (left_reg != 2'h0);
            left_reg    <= left_reg - 2'h1;
         end
      end
   end
endmodule // fsf_core_model

// ### fsf_fault_flags_tb.sv
// Purpose: self-checking bench for the fault flag slice
// Assumes: core model drives the fault strobes, bench is the apb master
// Notes: expectations are built by bench functions, never read from the design
`timescale 1ns/1ps
`include "fsf_defs.svh"
module fsf_fault_flags_tb
   import fsf_pkg::*;
;
   logic        clock = 1'b0, rst_n = 1'b0;                   // core clock and reset
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;   // apb controls
   logic [11:0] paddr = 12'h000;                              // apb address
   fsf_word_t   pwdata = 32'h0, prdata;                       // apb data
   logic        pready, pslverr, fault_irq;                   // apb answer, irq
   logic        ireq = 1'b0, ereq = 1'b0, breq = 1'b0, mreq = 1'b0, preq = 1'b0, vreq = 1'b0;
   logic [1:0]  lreq = 2'h0;                                  // model push length
   logic        c_iv, c_pe, c_bc, c_mc, c_pa, c_pv, c_pd;     // core strobes
   logic        f_ie, f_mv, f_pv, bus_en, mem_en, sp_en;      // design outputs
   int          n_mismatch = 0, n_compared = 0;              // report counters
   int          n_bus = 0, n_mem = 0, n_sp = 0;               // enable pulses seen
   int          e_bus = 0, e_mem = 0, e_sp = 0, i;            // enable pulses expected
   fsf_word_t   e_flags = 32'h0, e_stat = 32'h0, d;           // expected registers
   logic        err;                                          // slave error seen
   integer      seed = 32'hac17;                              // fixed seed

   fsf_fault_flags u_fsf_fault_flags (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_issue_valid(c_iv), .core_issue_prefetch_err(c_pe), .core_bus_addr_capture_req(c_bc),
      .core_mem_addr_capture_req(c_mc), .core_entry_push_active(c_pa), .core_entry_push_violation(c_pv),
      .core_entry_push_done(c_pd), .instr_fetch_error_flag(f_ie), .mem_fault_addr_valid(f_mv),
      .entry_push_violation_flag(f_pv), .bus_fault_addr_capture_en(bus_en),
      .mem_fault_addr_capture_en(mem_en), .stack_pointer_update_en(sp_en), .fault_irq(fault_irq));
   fsf_core_model u_fsf_core_model (.clock(clock), .rst_n(rst_n), .issue_req(ireq), .fetch_err_req(ereq),
      .bus_cap_req(breq), .mem_cap_req(mreq), .push_start(preq), .push_viol(vreq), .push_len(lreq),
      .issue_valid(c_iv), .prefetch_err(c_pe), .bus_cap(c_bc), .mem_cap(c_mc), .push_active(c_pa),
      .push_violation(c_pv), .push_done(c_pd));

   // 25 mhz core clock
   always #20 clock = ~clock;
   // count enable pulses, each stands one cycle
   always @(posedge clock) begin
      n_bus <= n_bus + int'(bus_en === 1'b1);
      n_mem <= n_mem + int'(mem_en === 1'b1);
      n_sp  <= n_sp + int'(sp_en === 1'b1);
   end

   // flag bits one event byte should set
   function automatic fsf_word_t exp_set(input logic [7:0] r);
      exp_set = 32'h0;
      exp_set[`FSF_BIT_INSTR_ERR] = r[0] & r[1];
      exp_set[`FSF_BIT_MEM_VALID] = r[3] & ~(r[4] & r[5]); // violation vetoes the capture
      exp_set[`FSF_BIT_PUSH_VIOL] = r[4] & r[5];
   endfunction

   task automatic check(input fsf_word_t seen, input fsf_word_t exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one apb transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [11:0] a, input fsf_word_t wd, output fsf_word_t rd);
      int n;
      @(posedge clock);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd  = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 16) begin            // hung slave
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   task automatic rd_chk(input logic [11:0] a, input fsf_word_t exp);
      apb(1'b0, a, 32'h0, d);
      check(d, exp);
   endtask

   task automatic wr_flags(input fsf_word_t wd);
      apb(1'b1, `FSF_FLAGS_OFS, wd, d);
      e_flags &= ~wd;
   endtask

   // one event byte through the core model, then let it settle
   task automatic evt(input logic [7:0] r);
      @(posedge clock);
      {lreq, vreq, preq, mreq, breq, ereq, ireq} <= r;
      @(posedge clock);
      {lreq, vreq, preq, mreq, breq, ereq, ireq} <= 8'h00;
      repeat (8) @(posedge clock);
      e_flags |= exp_set(r);
      e_stat  |= exp_set(r);
      e_bus   += int'(r[2] & ~(r[0] & r[1]));
      e_mem   += int'(r[3] & ~(r[4] & r[5]));
      e_sp    += int'(r[4]);
   endtask

   // main sequence: reset, directed corners, random events, interrupt
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      rd_chk(`FSF_FLAGS_OFS, `FSF_FLAGS_RST);
      rd_chk(`FSF_IRQ_STAT_OFS, `FSF_IRQ_STAT_RST);
      rd_chk(`FSF_IRQ_MASK_OFS, `FSF_IRQ_MASK_RST);
      rd_chk(12'h00c, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(1'b1, `FSF_IRQ_MASK_OFS, 32'hffff_ffff, d);
      rd_chk(`FSF_IRQ_MASK_OFS, `FSF_LIVE_MASK);
      apb(1'b1, `FSF_IRQ_MASK_OFS, 32'h0, d);
      evt(8'h02);                                    // prefetch error never issued
      rd_chk(`FSF_FLAGS_OFS, e_flags);
      evt(8'h07);                                    // issued, with bus capture asked
      rd_chk(`FSF_FLAGS_OFS, e_flags);
      check(n_bus, e_bus);
      // new set lands on the edge of the clearing write
      fork
         apb(1'b1, `FSF_FLAGS_OFS, 32'h100, d);
         begin
            repeat (3) @(posedge clock);
            {ireq, ereq} <= 2'b11;
            @(posedge clock);
            {ireq, ereq} <= 2'b00;
         end
      join
      rd_chk(`FSF_FLAGS_OFS, 32'h100);
      wr_flags(32'h100);
      evt(8'h08);                                    // accepted mem capture
      check({31'h0, f_mv}, 32'h1);
      wr_flags(32'h0);
      rd_chk(`FSF_FLAGS_OFS, e_flags);
      wr_flags(32'h80);
      rd_chk(`FSF_FLAGS_OFS, e_flags);
      evt(8'hb8);                                    // violating push, mem capture same cycle
      rd_chk(`FSF_FLAGS_OFS, e_flags);
      check(n_mem, e_mem);
      check(n_sp, e_sp);
      for (i = 0; i < 40; i++) begin
         evt(8'($random(seed)));
         check({23'h0, f_ie, f_mv, 2'b00, f_pv, 4'h0}, e_flags);
         rd_chk(`FSF_FLAGS_OFS, e_flags);
         wr_flags($random(seed));
      end
      check(n_bus, e_bus);
      check(n_mem, e_mem);
      check(n_sp, e_sp);
      check({31'h0, fault_irq}, 32'h0);
      apb(1'b1, `FSF_IRQ_MASK_OFS, 32'hffff_ffff, d);
      repeat (2) @(posedge clock);
      check({31'h0, fault_irq}, {31'h0, |e_stat});
      rd_chk(`FSF_IRQ_STAT_OFS, e_stat);
      repeat (2) @(posedge clock);
      check({31'h0, fault_irq}, 32'h0);
      rd_chk(`FSF_IRQ_STAT_OFS, 32'h0);
      tally_and_finish();
   end
endmodule // fsf_fault_flags_tb
